// file: common/bsa_regs.vh
// Constants for the battery status word logic
`ifndef BSA_REGS_VH
`define BSA_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BSA_STATUS_CMD 8'h16
`define BSA_RESET_CMD 8'h44
`define BSA_MAXERR_CMD 8'h0c
`define BSA_RESET_KEY 16'h8009
`define BSA_MAXERR_BLOCK 16'h0002
`define BSA_STATUS_RESET 16'h0000

// ----------------------------------------
// Error codes
// ----------------------------------------
`define BSA_ERR_OK 3'h0
`define BSA_ERR_BUSY 3'h1
`define BSA_ERR_NOT_READY 3'h2
`define BSA_ERR_UNSUPPORTED 3'h3
`define BSA_ERR_DENIED 3'h4
`define BSA_ERR_OVERFLOW 3'h5
`define BSA_ERR_BAD_SIZE 3'h6
`define BSA_ERR_UNKNOWN 3'h7

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define BSA_ERR_MSB 2
`define BSA_ERR_LSB 0
`define BSA_BIT_FULLY_DISCHARGED 4
`define BSA_BIT_FULLY_CHARGED 5
`define BSA_BIT_DISCHARGING 6
`define BSA_BIT_INITIALIZED 7
`define BSA_BIT_REM_TIME 8
`define BSA_BIT_REM_CAP 9
`define BSA_BIT_TERM_DISCHARGE 11
`define BSA_BIT_OVER_TEMP 12
`define BSA_BIT_TEMP_RATE 13
`define BSA_BIT_TERM_CHARGE 14
`define BSA_BIT_OVER_CHARGE 15

// Size of a word write in bytes
`define BSA_WORD_BYTES 2'h2

// Relative charge at which fully discharged clears
`define BSA_RSOC_RECOVER 7'h14
`endif

// file: verilog/bsa_status.v
// Battery status word: error code, alarm flags and status flags

`include "bsa_regs.vh"

module bsa_status (
    input wire CLOCK,
    input wire RST,
    input wire CFG_LOADED,
    input wire WRITE_INHIBIT_FLAG,
    input wire CMD_VALID,
    input wire CMD_WRITE,
    input wire [7:0] CMD_CODE,
    input wire [1:0] CMD_BYTES,
    input wire [15:0] CMD_WDATA,
    input wire CMD_SUPPORTED,
    input wire CMD_READ_ONLY,
    input wire CMD_BUSY,
    input wire CMD_OVERFLOW,
    input wire CMD_UNKNOWN,
    input wire CHARGING,
    input wire VALID_CHARGE,
    input wire VALID_TERMINATION,
    input wire OVER_CURRENT,
    input wire OVER_VOLTAGE,
    input wire TEMP_ABOVE_MAX,
    input wire TEMP_BELOW_50C,
    input wire TEMP_RATE_HIGH,
    input wire BELOW_FINAL_DISCHARGE_VOLTAGE,
    input wire CAP_BELOW_ALARM,
    input wire CAP_RISING,
    input wire TIME_BELOW_ALARM,
    input wire FULL_OR_EMPTY,
    input wire BELOW_FULL_PERCENT,
    input wire DAMAGE_LIMIT,
    input wire [6:0] RELATIVE_CHARGE,
    output reg [15:0] STATUS_WORD,
    output reg CHARGE_REQUEST_ZERO,
    output reg SET_CAP_TO_FULL,
    output reg SOFT_RESET
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [2:0] err_code;
    wire over_charge;
    wire term_charge;
    wire temp_rate;
    wire over_temp;
    wire term_discharge;
    wire rem_cap;
    wire rem_time;
    wire initialized;
    wire discharging;
    wire fully_charged;
    wire fully_discharged;
    reg maxerr_ok;
    reg [2:0] next_err_code;
    wire is_status_read;
    wire soft_reset_hit;
    wire charge_fault;
    wire temp_trip;
    wire cap_alarm_hold;
    wire time_alarm_hold;

    // A valid write of the reset key after the max-error preset
    assign soft_reset_hit = CMD_VALID && CMD_WRITE && CMD_CODE == `BSA_RESET_CMD && !WRITE_INHIBIT_FLAG
        && maxerr_ok && CMD_WDATA == `BSA_RESET_KEY;
    assign is_status_read = CMD_VALID && !CMD_WRITE;
    assign charge_fault = OVER_CURRENT | OVER_VOLTAGE | TEMP_ABOVE_MAX | TEMP_RATE_HIGH;
    // Alarm conditions that each feed one flag's set and clear
    assign temp_trip = TEMP_ABOVE_MAX || TEMP_RATE_HIGH;
    assign cap_alarm_hold = CAP_BELOW_ALARM && !(CHARGING && CAP_RISING);
    assign time_alarm_hold = TIME_BELOW_ALARM && !VALID_CHARGE;

    // ----------------------------------------
    // Error code selection, by priority
    // ----------------------------------------
    always @* begin
        next_err_code = err_code;
        if (CMD_VALID) begin
            if (!CFG_LOADED) begin
                next_err_code = `BSA_ERR_NOT_READY;
            end else if (CMD_BUSY) begin
                next_err_code = `BSA_ERR_BUSY;
            end else if (!CMD_SUPPORTED) begin
                next_err_code = `BSA_ERR_UNSUPPORTED;
            end else if (CMD_WRITE && CMD_READ_ONLY) begin
                next_err_code = `BSA_ERR_DENIED;
            end else if (CMD_WRITE && CMD_BYTES != `BSA_WORD_BYTES) begin
                next_err_code = `BSA_ERR_BAD_SIZE;
            end else if (CMD_OVERFLOW) begin
                next_err_code = `BSA_ERR_OVERFLOW;
            end else if (CMD_UNKNOWN) begin
                next_err_code = `BSA_ERR_UNKNOWN;
            end else if (is_status_read) begin
                next_err_code = `BSA_ERR_OK;
            end else begin
                next_err_code = `BSA_ERR_OK;
            end
        end
    end

    // ----------------------------------------
    // Error code register
    // ----------------------------------------
    // A user reset returns the code to no error
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            err_code <= `BSA_ERR_OK;
        end else if (soft_reset_hit) begin
            err_code <= `BSA_ERR_OK;
        end else begin
            err_code <= next_err_code;
        end
    end

    // ----------------------------------------
    // Reset key arming
    // ----------------------------------------
    // Arm the reset key when max error is written other than two
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            maxerr_ok <= 1'b0;
        end else if (soft_reset_hit) begin
            maxerr_ok <= 1'b0;
        end else if (CMD_VALID && CMD_WRITE && CMD_CODE == `BSA_MAXERR_CMD && !WRITE_INHIBIT_FLAG) begin
            maxerr_ok <= (CMD_WDATA != `BSA_MAXERR_BLOCK);
        end
    end

    // ----------------------------------------
    // Alarm flags
    // ----------------------------------------
    // Over-charge alarm on a temperature based termination during charge
    bsa_flag i_flag_over_charge (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(CHARGING && VALID_TERMINATION && temp_trip),
        .clear(!CHARGING || !temp_trip),
        .flag(over_charge)
    );
    // Terminate-charge alarm follows the charge faults
    bsa_flag i_flag_term_charge (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(CHARGING && charge_fault),
        .clear(!(CHARGING && charge_fault)),
        .flag(term_charge)
    );
    // Temperature-rate alarm follows the rise rate
    bsa_flag i_flag_temp_rate (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(TEMP_RATE_HIGH),
        .clear(!TEMP_RATE_HIGH),
        .flag(temp_rate)
    );
    // Over-temp has hysteresis down to 50 C
    bsa_flag i_flag_over_temp (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(TEMP_ABOVE_MAX),
        .clear(TEMP_BELOW_50C),
        .flag(over_temp)
    );
    // Terminate-discharge alarm follows the final voltage threshold
    bsa_flag i_flag_term_discharge (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(BELOW_FINAL_DISCHARGE_VOLTAGE),
        .clear(!BELOW_FINAL_DISCHARGE_VOLTAGE),
        .flag(term_discharge)
    );
    // Capacity alarm clears on lower level or charging growth
    bsa_flag i_flag_rem_cap (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(cap_alarm_hold),
        .clear(!cap_alarm_hold),
        .flag(rem_cap)
    );
    // Time alarm clears on lower setting or a valid charge
    bsa_flag i_flag_rem_time (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(time_alarm_hold),
        .clear(!time_alarm_hold),
        .flag(rem_time)
    );

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Initialized only clears on a power-on or user reset
    bsa_flag i_flag_initialized (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(FULL_OR_EMPTY),
        .clear(1'b0),
        .flag(initialized)
    );
    // Discharging whenever no charge is seen
    bsa_flag i_flag_discharging (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(!CHARGING),
        .clear(CHARGING),
        .flag(discharging)
    );
    // Fully charged sets on termination, clears below full percentage
    bsa_flag i_flag_fully_charged (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(VALID_TERMINATION),
        .clear(BELOW_FULL_PERCENT),
        .flag(fully_charged)
    );
    // Fully discharged holds until the relative charge recovers
    bsa_flag i_flag_fully_discharged (
        .clock(CLOCK),
        .rst(RST),
        .clear_all(soft_reset_hit),
        .set(DAMAGE_LIMIT),
        .clear(RELATIVE_CHARGE >= `BSA_RSOC_RECOVER),
        .flag(fully_discharged)
    );

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            STATUS_WORD <= `BSA_STATUS_RESET;
            CHARGE_REQUEST_ZERO <= 1'b0;
            SET_CAP_TO_FULL <= 1'b0;
            SOFT_RESET <= 1'b0;
        end else begin
            STATUS_WORD <= `BSA_STATUS_RESET;
            STATUS_WORD[`BSA_ERR_MSB:`BSA_ERR_LSB] <= err_code;
            STATUS_WORD[`BSA_BIT_OVER_CHARGE] <= over_charge;
            STATUS_WORD[`BSA_BIT_TERM_CHARGE] <= term_charge;
            STATUS_WORD[`BSA_BIT_TEMP_RATE] <= temp_rate;
            STATUS_WORD[`BSA_BIT_OVER_TEMP] <= over_temp;
            STATUS_WORD[`BSA_BIT_TERM_DISCHARGE] <= term_discharge;
            STATUS_WORD[`BSA_BIT_REM_CAP] <= rem_cap;
            STATUS_WORD[`BSA_BIT_REM_TIME] <= rem_time;
            STATUS_WORD[`BSA_BIT_INITIALIZED] <= initialized;
            STATUS_WORD[`BSA_BIT_DISCHARGING] <= discharging;
            STATUS_WORD[`BSA_BIT_FULLY_CHARGED] <= fully_charged;
            STATUS_WORD[`BSA_BIT_FULLY_DISCHARGED] <= fully_discharged;
            CHARGE_REQUEST_ZERO <= term_charge;
            SET_CAP_TO_FULL <= CHARGING && VALID_TERMINATION;
            SOFT_RESET <= soft_reset_hit;
        end
    end

endmodule

// ----------------------------------------
// One alarm or status flag
// ----------------------------------------
module bsa_flag (
    input wire clock,
    input wire rst,
    input wire clear_all,
    input wire set,
    input wire clear,
    output reg flag
);

    // Set wins when set and clear meet; a user reset clears all
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (clear_all) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

endmodule

// file: sim/bsa_host.sv
// Host and configuration memory model on the command side
module bsa_host (
    input wire logic CLOCK,
    output logic CFG_LOADED, WRITE_INHIBIT_FLAG, CMD_VALID, CMD_WRITE, CMD_SUPPORTED,
    output logic CMD_READ_ONLY, CMD_BUSY, CMD_OVERFLOW, CMD_UNKNOWN,
    output logic [7:0] CMD_CODE,
    output logic [1:0] CMD_BYTES,
    output logic [15:0] CMD_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    // Memory not read yet, writes allowed, link idle
    initial begin
        {CFG_LOADED, WRITE_INHIBIT_FLAG, CMD_VALID, CMD_WRITE, CMD_CODE, CMD_BYTES, CMD_WDATA} = '0;
        {CMD_SUPPORTED, CMD_READ_ONLY, CMD_BUSY, CMD_OVERFLOW, CMD_UNKNOWN} = '0;
    end
    // One command for a cycle; afterwards only code and data show the inverse
    task cmd(input logic w, input logic [7:0] c, input logic [1:0] b, input logic [15:0] d, input logic [4:0] q);
        @(posedge CLOCK);
        {CMD_VALID, CMD_WRITE, CMD_CODE, CMD_BYTES, CMD_WDATA} <= {1'b1, w, c, b, d};
        {CMD_SUPPORTED, CMD_READ_ONLY, CMD_BUSY, CMD_OVERFLOW, CMD_UNKNOWN} <= q;
        @(posedge CLOCK);
        {CMD_VALID, CMD_CODE, CMD_WDATA} <= {1'b0, ~c, ~d};
        @(posedge CLOCK);
    endtask
endmodule

// file: sim/bsa_status_asserts.sv
// Checker on the ports of the status word logic
module bsa_status_chk (
    input wire CLOCK, RST, CFG_LOADED, WRITE_INHIBIT_FLAG, CMD_VALID, CMD_WRITE, CMD_SUPPORTED,
    input wire CMD_READ_ONLY, CMD_BUSY, CMD_OVERFLOW, CMD_UNKNOWN, CHARGING, TEMP_BELOW_50C, TEMP_RATE_HIGH,
    input wire [7:0] CMD_CODE,
    input wire [15:0] CMD_WDATA, STATUS_WORD,
    input wire [6:0] RELATIVE_CHARGE,
    input wire CHARGE_REQUEST_ZERO, SOFT_RESET, VALID_TERMINATION, SET_CAP_TO_FULL
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic [2:0] hist;
    logic key;
    logic quiet;
    logic ok_cmd;
    // Age since any reset, and a registered accepted-key write
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            hist <= 3'h7;
            key <= 1'b0;
        end else begin
            hist <= {hist[1:0], SOFT_RESET};
            key <= CMD_VALID && CMD_WRITE && CMD_CODE == 8'h44 && CMD_WDATA == 16'h8009 && !WRITE_INHIBIT_FLAG;
        end
    end
    assign quiet = hist == 3'h0 && !SOFT_RESET;
    assign ok_cmd = CMD_VALID && CFG_LOADED && !CMD_BUSY && CMD_SUPPORTED;
    rate_alarm_a: assert property (quiet |-> STATUS_WORD[13] == $past(TEMP_RATE_HIGH, 2))
        else $error("rate alarm wrong");
    discharging_a: assert property (quiet |-> STATUS_WORD[6] == !$past(CHARGING, 2))
        else $error("discharging bit wrong");
    over_temp_hold_a: assert property (quiet && $fell(STATUS_WORD[12]) |-> $past(TEMP_BELOW_50C, 2))
        else $error("over temp cleared too early");
    full_dis_hold_a: assert property (quiet && $fell(STATUS_WORD[4]) |-> $past(RELATIVE_CHARGE, 2) >= 7'h14)
        else $error("fully discharged cleared too early");
    req_zero_a: assert property (quiet |-> CHARGE_REQUEST_ZERO == STATUS_WORD[14])
        else $error("charge request not zeroed");
    cap_full_a: assert property (CHARGING && VALID_TERMINATION |=> SET_CAP_TO_FULL)
        else $error("capacity not raised to full");
    not_ready_a: assert property (CMD_VALID && !CFG_LOADED |-> ##2 STATUS_WORD[2:0] == 3'h2)
        else $error("not ready code missing");
    denied_a: assert property (ok_cmd && CMD_WRITE && CMD_READ_ONLY |-> ##2 STATUS_WORD[2:0] == 3'h4)
        else $error("denied code missing");
    read_clear_a: assert property (ok_cmd && !CMD_WRITE && !CMD_OVERFLOW && !CMD_UNKNOWN |-> ##2 STATUS_WORD[2:0] == 3'h0)
        else $error("read did not clear code");
    reset_pulse_a: assert property (SOFT_RESET |-> key ##1 !SOFT_RESET)
        else $error("soft reset pulse wrong");
endmodule
bind bsa_status bsa_status_chk i_bsa_status_chk (.*);

// file: sim/tb_bsa_status.sv
// Self-checking bench for the battery status word logic
module tb_bsa_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK, RST, CHARGING, VALID_CHARGE, VALID_TERMINATION, OVER_CURRENT, OVER_VOLTAGE, TEMP_ABOVE_MAX;
    logic TEMP_BELOW_50C, TEMP_RATE_HIGH, BELOW_FINAL_DISCHARGE_VOLTAGE, CAP_BELOW_ALARM, CAP_RISING;
    logic TIME_BELOW_ALARM, FULL_OR_EMPTY, BELOW_FULL_PERCENT, DAMAGE_LIMIT, CHARGE_REQUEST_ZERO, SET_CAP_TO_FULL;
    logic SOFT_RESET, CFG_LOADED, WRITE_INHIBIT_FLAG, CMD_VALID, CMD_WRITE, CMD_SUPPORTED, CMD_READ_ONLY;
    logic CMD_BUSY, CMD_OVERFLOW, CMD_UNKNOWN, v1 = 1'b0, v2 = 1'b0, due = 1'b0, want_rst;
    logic [7:0] CMD_CODE;
    logic [1:0] CMD_BYTES;
    logic [6:0] RELATIVE_CHARGE;
    logic [14:0] g;
    logic [15:0] CMD_WDATA, STATUS_WORD;
    logic [31:0] exp_q[$], e, r;
    logic [63:0] ft [13] = '{64'h0200_0000_1000_1000, 64'h0000_0000_1000_1000, 64'h0100_0000_0000_1000,
        64'h4800_0000_4000_4000, 64'h0000_0000_0000_4000, 64'h0001_000a_0010_0010, 64'h0000_0013_0010_0010,
        64'h0000_0014_0000_0010, 64'h5080_0014_8020_8020, 64'h0002_0014_0000_8020, 64'h0028_0014_0300_0300,
        64'h6038_0014_0000_0300, 64'h0004_0014_0080_0080};
    localparam logic [29:0] TQ = {5'h14, 5'h00, 5'h18, 5'h10, 5'h12, 5'h11};
    localparam logic [17:0] TE = {3'h1, 3'h3, 3'h4, 3'h6, 3'h5, 3'h7};
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int i;
    always @* {CHARGING, VALID_CHARGE, VALID_TERMINATION, OVER_CURRENT, OVER_VOLTAGE, TEMP_ABOVE_MAX, TEMP_BELOW_50C,
        TEMP_RATE_HIGH, BELOW_FINAL_DISCHARGE_VOLTAGE, CAP_BELOW_ALARM, CAP_RISING, TIME_BELOW_ALARM,
        FULL_OR_EMPTY, BELOW_FULL_PERCENT, DAMAGE_LIMIT} = g;
    bsa_status i_bsa_status (.*);
    bsa_host i_bsa_host (.*);
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    task check_word(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: status %h expected %h", $time, got, want);
        end
    endtask
    task check_pulse(input logic got, input logic want);
        n_tests++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: pulse %h expected %h", $time, got, want);
        end
    endtask
    task complete_run;
        $display("%0d checks, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Note the expected bits, then hand the command to the host
    task send(input logic w, input logic [7:0] c, input logic [1:0] b, input logic [15:0] d, input logic [4:0] q,
        input logic [15:0] want, input logic [15:0] mask);
        exp_q.push_back({want, mask});
        i_bsa_host.cmd(w, c, b, d, q);
    endtask
    // Set gauge levels, then read the status word
    task flags(input logic [14:0] gv, input logic [6:0] rc, input logic [15:0] want, input logic [15:0] mask);
        @(posedge CLOCK);
        g <= gv;
        RELATIVE_CHARGE <= rc;
        send(1'b0, 8'h16, 2'h2, 16'($urandom), 5'h10, want, mask);
    endtask
    // Result of a command shows two edges after it is taken
    always @(posedge CLOCK) begin
        v1 <= CMD_VALID;
        v2 <= v1;
        if (v2) begin
            e = exp_q.pop_front();
            check_word(STATUS_WORD & e[15:0], e[31:16] & e[15:0]);
        end
        if (v1 && due) begin
            check_pulse(SOFT_RESET, want_rst);
            due <= 1'b0;
        end
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        RST = 1'b1;
        g = '0;
        RELATIVE_CHARGE = 7'h00;
        void'($urandom(10046));
        repeat (6) @(posedge CLOCK);
        RST <= 1'b0;
        send(1'b0, 8'h16, 2'h2, 16'h0000, 5'h10, 16'h0002, 16'h0007);
        i_bsa_host.CFG_LOADED <= 1'b1;
        for (i = 0; i < 6; i++) begin
            send(i == 2 || i == 3, 8'($urandom), (i == 3) ? 2'h1 : 2'h2, 16'($urandom), TQ[25 - 5 * i +: 5],
                {13'h0000, TE[15 - 3 * i +: 3]}, 16'h0007);
            send(1'b0, 8'h16, 2'h2, 16'h0000, 5'h10, 16'h0000, 16'h0007);
        end
        $display("error codes done");
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            flags({r[2], 6'h00, r[0], r[1], 6'h00}, r[15:9], {2'h0, r[0], 1'b0, r[1], 4'h0, ~r[2], 6'h00},
                16'h2847);
        end
        $display("random levels done");
        for (i = 0; i < 13; i++)
            flags(ft[i][62:48], ft[i][38:32], ft[i][31:16], ft[i][15:0]);
        $display("alarm table done");
        g <= '0;
        for (i = 1; i >= 0; i--) begin
            i_bsa_host.WRITE_INHIBIT_FLAG <= i[0];
            send(1'b1, 8'h0c, 2'h2, 16'h0001, 5'h10, 16'h0000, 16'h0007);
            due <= 1'b1;
            want_rst <= ~i[0];
            send(1'b1, 8'h44, 2'h2, 16'h8009, 5'h10, 16'h0000, 16'h0007);
        end
        flags(15'h0000, 7'h14, 16'h0000, 16'h0080);
        $display("soft reset done");
        repeat (4) @(posedge CLOCK);
        complete_run();
    end
endmodule
